// [pkg/sddma_pkg.sv]
// Purpose: constants for the socket distributed dma slave channel
// Assumes: byte-wide register port on a 16-byte i/o window
// Notes:   offsets are byte offsets inside the window
`default_nettype none
package sddma_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned FIFO_DEPTH = 8;
	// register offsets
	localparam logic [3:0] OFS_ADDR_LO = 4'h0;
	localparam logic [3:0] OFS_ADDR_HI = 4'h1;
	localparam logic [3:0] OFS_PAGE = 4'h2;
	localparam logic [3:0] OFS_COUNT_LO = 4'h4;
	localparam logic [3:0] OFS_COUNT_HI = 4'h5;
	localparam logic [3:0] OFS_CMD_STATUS = 4'h8;
	localparam logic [3:0] OFS_SW_REQUEST = 4'h9;
	localparam logic [3:0] OFS_MODE = 4'hB;
	localparam logic [3:0] OFS_CLEAR = 4'hD;
	localparam logic [3:0] OFS_MASK = 4'hF;
	// field positions
	localparam int unsigned CMD_DISABLE_BIT = 2;
	localparam int unsigned MODE_SEL_HI = 7;
	localparam int unsigned MODE_SEL_LO = 6;
	localparam int unsigned MODE_STEP_BIT = 5;
	localparam int unsigned MODE_AUTO_BIT = 4;
	localparam int unsigned MODE_DIR_HI = 3;
	localparam int unsigned MODE_DIR_LO = 2;
	localparam int unsigned MASK_BIT = 0;
	// reset values
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic DISABLE_RST = 1'b0;
	localparam logic MASK_RST = 1'b1;
	localparam logic [5:0] MODE_RST = 6'h00;
	// count decrement and address step per transfer
	localparam logic [15:0] STEP_NARROW = 16'h0001;
	localparam logic [15:0] STEP_WIDE = 16'h0002;
	localparam logic [15:0] ADDR_STEP = 16'h0001;
	typedef enum logic [1:0] {
		XM_DEMAND = 2'b00,
		XM_SINGLE = 2'b01,
		XM_BLOCK = 2'b10,
		XM_RSVD = 2'b11
	} sddma_xmode_t;
	typedef enum logic [1:0] {
		XD_NONE = 2'b00,
		XD_WRITE = 2'b01,
		XD_READ = 2'b10,
		XD_RSVD = 2'b11
	} sddma_xdir_t;
endpackage
`default_nettype wire

// [core/sddma_channel.sv]
// Purpose: register and control logic of one distributed dma slave channel
// Assumes: one clock; card request pin is asynchronous
// Notes:   data path holds an 8-word fifo between source and sink
`default_nettype none

module sddma_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
	logic [PW:0]      cnt_q, cnt_d;
	logic             push, pop;

	always_comb begin
		in_ready = (cnt_q != (PW+1)'(DEPTH));
		out_valid = (cnt_q != '0);
		out_data = mem_q[rp_q];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// storage needs no reset; empty flag guards stale words
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end
endmodule

module sddma_channel (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  io_addr,
	input  wire logic        io_wr_en,
	input  wire logic        io_rd_en,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	output logic             io_rvalid,
	input  wire logic        card_dma_request,
	input  wire logic        wide_xfer,
	input  wire logic        card_in_valid,
	output logic             card_in_ready,
	input  wire logic [15:0] card_in_data,
	input  wire logic        mem_in_valid,
	output logic             mem_in_ready,
	input  wire logic [15:0] mem_in_data,
	output logic             mem_out_valid,
	input  wire logic        mem_out_ready,
	output logic      [15:0] mem_out_data,
	output logic             card_out_valid,
	input  wire logic        card_out_ready,
	output logic      [15:0] card_out_data,
	output logic             dma_request_out,
	output logic      [23:0] addr_phase
);
	typedef enum logic [1:0] {
		CH_IDLE,
		CH_ACTIVE,
		CH_WAIT_DROP,
		CH_DONE
	} sddma_ch_t;

	sddma_ch_t   st_q, st_d;
	logic [15:0] base_cnt_q, base_cnt_d, cur_cnt_q, cur_cnt_d;
	logic [15:0] base_adr_q, base_adr_d, cur_adr_q, cur_adr_d;
	logic [7:0]  page_q, page_d;
	logic        dis_q, dis_d, mask_q, mask_d, tc_q, tc_d;
	logic        swreq_q, swreq_d;
	logic [5:0]  mode_q, mode_d;
	logic [2:0]  sync_q;
	logic        creq_q, creq_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        rvalid_q;
	logic        omem_q, omem_d, ocard_q, ocard_d;
	logic [15:0] odata_q, odata_d;
	logic        card_dma_request_q, card_dma_request_d;
	logic [23:0] aph_q, aph_d;

	sddma_pkg::sddma_xmode_t xmode;
	sddma_pkg::sddma_xdir_t  xdir;
	logic        req_any, push_ok, src_valid, push;
	logic [15:0] src_data, step;
	logic        f_ready, f_valid, f_pop, sink_rdy;
	logic [15:0] f_data;

	assign xmode = sddma_pkg::sddma_xmode_t'(
		mode_q[sddma_pkg::MODE_SEL_HI-2:sddma_pkg::MODE_SEL_LO-2]);
	assign xdir = sddma_pkg::sddma_xdir_t'(
		mode_q[sddma_pkg::MODE_DIR_HI-2:sddma_pkg::MODE_DIR_LO-2]);

	sddma_fifo #(
		.WIDTH (sddma_pkg::DATA_W),
		.DEPTH (sddma_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (push),
		.in_ready  (f_ready),
		.in_data   (src_data),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_data)
	);

	always_comb begin
		// mask gates service only; status bits see the raw line
		req_any = (creq_q && !mask_q) || swreq_q;
		push_ok = (st_q == CH_ACTIVE) && !dis_q && f_ready
			&& (req_any || xmode == sddma_pkg::XM_BLOCK)
			&& (xdir == sddma_pkg::XD_WRITE
			|| xdir == sddma_pkg::XD_READ);
		// card feeds memory on write, memory feeds card on read
		src_valid = (xdir == sddma_pkg::XD_WRITE) ? card_in_valid
			: mem_in_valid;
		src_data = (xdir == sddma_pkg::XD_WRITE) ? card_in_data
			: mem_in_data;
		push = push_ok && src_valid;
		card_in_ready = push_ok && (xdir == sddma_pkg::XD_WRITE);
		mem_in_ready = push_ok && (xdir == sddma_pkg::XD_READ);
		step = wide_xfer ? sddma_pkg::STEP_WIDE
			: sddma_pkg::STEP_NARROW;
		sink_rdy = (omem_q && mem_out_ready)
			|| (ocard_q && card_out_ready);
		f_pop = f_valid && (!(omem_q || ocard_q) || sink_rdy);
	end

	always_comb begin
		st_d = st_q;
		base_cnt_d = base_cnt_q;
		cur_cnt_d = cur_cnt_q;
		base_adr_d = base_adr_q;
		cur_adr_d = cur_adr_q;
		page_d = page_q;
		dis_d = dis_q;
		mask_d = mask_q;
		tc_d = tc_q;
		swreq_d = swreq_q;
		mode_d = mode_q;
		// a change counts once the two later stages agree
		creq_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : creq_q;
		rdata_d = 8'h00;
		if (io_rd_en && io_addr == sddma_pkg::OFS_CMD_STATUS) begin
			tc_d = 1'b0;
		end
		case (st_q)
			CH_IDLE: begin
				if (req_any && !dis_q) begin
					st_d = CH_ACTIVE;
				end
			end
			CH_ACTIVE: begin
				if (!req_any && xmode != sddma_pkg::XM_BLOCK) begin
					st_d = CH_IDLE;
				end
			end
			CH_WAIT_DROP: begin
				// single mode: one transfer per request
				if (!req_any) begin
					st_d = CH_IDLE;
				end
			end
			CH_DONE: st_d = CH_DONE;
			default: st_d = CH_IDLE;
		endcase
		if (push) begin
			cur_cnt_d = cur_cnt_q - step;
			cur_adr_d = mode_q[sddma_pkg::MODE_STEP_BIT-2]
				? cur_adr_q - sddma_pkg::ADDR_STEP
				: cur_adr_q + sddma_pkg::ADDR_STEP;
			if (cur_cnt_q <= step) begin
				tc_d = 1'b1;
				swreq_d = 1'b0;
				if (mode_q[sddma_pkg::MODE_AUTO_BIT-2]) begin
					cur_cnt_d = base_cnt_q;
					cur_adr_d = base_adr_q;
					st_d = CH_IDLE;
				end else begin
					st_d = CH_DONE;
				end
			end else if (xmode == sddma_pkg::XM_SINGLE) begin
				st_d = CH_WAIT_DROP;
			end
		end
		if (io_wr_en) begin
			case (io_addr)
				sddma_pkg::OFS_ADDR_LO: begin
					base_adr_d[7:0] = io_wdata;
					cur_adr_d[7:0] = io_wdata;
				end
				sddma_pkg::OFS_ADDR_HI: begin
					base_adr_d[15:8] = io_wdata;
					cur_adr_d[15:8] = io_wdata;
				end
				sddma_pkg::OFS_PAGE: page_d = io_wdata;
				sddma_pkg::OFS_COUNT_LO: begin
					base_cnt_d[7:0] = io_wdata;
					cur_cnt_d[7:0] = io_wdata;
					st_d = CH_IDLE;
				end
				sddma_pkg::OFS_COUNT_HI: begin
					base_cnt_d[15:8] = io_wdata;
					cur_cnt_d[15:8] = io_wdata;
					st_d = CH_IDLE;
				end
				sddma_pkg::OFS_CMD_STATUS:
					dis_d = io_wdata[sddma_pkg::CMD_DISABLE_BIT];
				sddma_pkg::OFS_SW_REQUEST: swreq_d = 1'b1;
				sddma_pkg::OFS_MODE: begin
					mode_d = io_wdata[7:2];
					st_d = CH_IDLE;
				end
				sddma_pkg::OFS_MASK:
					mask_d = io_wdata[sddma_pkg::MASK_BIT];
				default: ;
			endcase
		end
		if (io_rd_en) begin
			case (io_addr)
				sddma_pkg::OFS_ADDR_LO: rdata_d = cur_adr_q[7:0];
				sddma_pkg::OFS_ADDR_HI: rdata_d = cur_adr_q[15:8];
				sddma_pkg::OFS_PAGE: rdata_d = page_q;
				sddma_pkg::OFS_COUNT_LO: rdata_d = cur_cnt_q[7:0];
				sddma_pkg::OFS_COUNT_HI: rdata_d = cur_cnt_q[15:8];
				// status reads the raw request, not the masked one
				sddma_pkg::OFS_CMD_STATUS:
					rdata_d = {{4{creq_q}}, {4{tc_q}}};
				sddma_pkg::OFS_MODE: rdata_d = {mode_q, 2'b00};
				sddma_pkg::OFS_MASK: rdata_d = {7'h00, mask_q};
				default: rdata_d = 8'h00;
			endcase
		end
		if (io_wr_en && io_addr == sddma_pkg::OFS_CLEAR) begin
			st_d = CH_IDLE;
			base_cnt_d = sddma_pkg::COUNT_RST;
			cur_cnt_d = sddma_pkg::COUNT_RST;
			base_adr_d = sddma_pkg::ADDR_RST;
			cur_adr_d = sddma_pkg::ADDR_RST;
			page_d = sddma_pkg::PAGE_RST;
			dis_d = sddma_pkg::DISABLE_RST;
			mask_d = sddma_pkg::MASK_RST;
			tc_d = 1'b0;
			swreq_d = 1'b0;
			mode_d = sddma_pkg::MODE_RST;
		end
		// output stage keeps every data output on a flop
		omem_d = omem_q && !mem_out_ready;
		ocard_d = ocard_q && !card_out_ready;
		odata_d = odata_q;
		if (f_pop) begin
			omem_d = (xdir == sddma_pkg::XD_WRITE);
			ocard_d = (xdir != sddma_pkg::XD_WRITE);
			odata_d = f_data;
		end
		card_dma_request_d = (st_q == CH_ACTIVE) && req_any && !dis_q;
		aph_d = wide_xfer ? {page_q[7:1], cur_adr_q, 1'b0}
			: {page_q, cur_adr_q};
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= CH_IDLE;
			base_cnt_q <= sddma_pkg::COUNT_RST;
			cur_cnt_q <= sddma_pkg::COUNT_RST;
			base_adr_q <= sddma_pkg::ADDR_RST;
			cur_adr_q <= sddma_pkg::ADDR_RST;
			page_q <= sddma_pkg::PAGE_RST;
			dis_q <= sddma_pkg::DISABLE_RST;
			mask_q <= sddma_pkg::MASK_RST;
			tc_q <= 1'b0;
			swreq_q <= 1'b0;
			mode_q <= sddma_pkg::MODE_RST;
			sync_q <= 3'b000;
			creq_q <= 1'b0;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			omem_q <= 1'b0;
			ocard_q <= 1'b0;
			odata_q <= 16'h0000;
			card_dma_request_q <= 1'b0;
			aph_q <= 24'h00_0000;
		end else begin
			st_q <= st_d;
			base_cnt_q <= base_cnt_d;
			cur_cnt_q <= cur_cnt_d;
			base_adr_q <= base_adr_d;
			cur_adr_q <= cur_adr_d;
			page_q <= page_d;
			dis_q <= dis_d;
			mask_q <= mask_d;
			tc_q <= tc_d;
			swreq_q <= swreq_d;
			mode_q <= mode_d;
			sync_q <= {sync_q[1:0], card_dma_request};
			creq_q <= creq_d;
			rdata_q <= rdata_d;
			rvalid_q <= io_rd_en;
			omem_q <= omem_d;
			ocard_q <= ocard_d;
			odata_q <= odata_d;
			card_dma_request_q <= card_dma_request_d;
			aph_q <= aph_d;
		end
	end

	assign io_rdata = rdata_q;
	assign io_rvalid = rvalid_q;
	assign mem_out_valid = omem_q;
	assign mem_out_data = odata_q;
	assign card_out_valid = ocard_q;
	assign card_out_data = odata_q;
	assign dma_request_out = card_dma_request_q;
	assign addr_phase = aph_q;
endmodule
`default_nettype wire

// [sim/sddma_channel_asserts.sv]
// Purpose: port checks for the dma slave channel
// Assumes: one clock, async active-high reset
// Notes:   bound to every sddma_channel
`default_nettype none
module sddma_channel_asserts (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [3:0]  io_addr,
	input wire logic        io_wr_en,
	input wire logic        io_rd_en,
	input wire logic [7:0]  io_rdata,
	input wire logic        io_rvalid,
	input wire logic        wide_xfer,
	input wire logic [23:0] addr_phase,
	input wire logic        mem_out_valid,
	input wire logic        mem_out_ready,
	input wire logic [15:0] mem_out_data,
	input wire logic        card_out_valid,
	input wire logic        card_out_ready,
	input wire logic [15:0] card_out_data
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic clr;
	logic rd_st;
	assign clr = io_wr_en && io_addr == sddma_pkg::OFS_CLEAR;
	assign rd_st = io_rd_en && io_addr == sddma_pkg::OFS_CMD_STATUS;
	read_answer_a: assert property (io_rd_en |=> io_rvalid)
		else $error("read not answered");
	idle_rdata_a: assert property (!io_rd_en |=> !io_rvalid && !io_rdata)
		else $error("read data without read");
	mode_low_a: assert property (io_rd_en && io_addr == sddma_pkg::OFS_MODE
		|=> io_rdata[1:0] == 2'b00) else $error("mode low bits set");
	status_group_a: assert property (rd_st |=>
		io_rdata[7:4] inside {4'h0, 4'hf} && io_rdata[3:0] inside {4'h0, 4'hf})
		else $error("status bits split");
	wo_read_a: assert property (io_rd_en
		&& (io_addr == 4'h9 || io_addr == 4'hd)
		|=> io_rdata == 8'h00) else $error("write-only read not zero");
	clear_count_a: assert property (clr ##1 !io_wr_en ##1
		(io_rd_en && io_addr == 4'h4) |=> io_rdata == 8'h00)
		else $error("count survived clear");
	wide_low_a: assert property ($past(wide_xfer) |-> !addr_phase[0])
		else $error("wide address bit 0 high");
	mem_hold_a: assert property (mem_out_valid && !mem_out_ready && !clr
		|=> mem_out_valid && $stable(mem_out_data)) else $error("mem word lost");
	card_hold_a: assert property (card_out_valid && !card_out_ready && !clr
		|=> card_out_valid && $stable(card_out_data)) else $error("card word lost");
endmodule
bind sddma_channel sddma_channel_asserts sddma_channel_asserts_i (
	.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr_en(io_wr_en),
	.io_rd_en(io_rd_en), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
	.wide_xfer(wide_xfer), .addr_phase(addr_phase),
	.mem_out_valid(mem_out_valid), .mem_out_ready(mem_out_ready),
	.mem_out_data(mem_out_data), .card_out_valid(card_out_valid),
	.card_out_ready(card_out_ready), .card_out_data(card_out_data));
`default_nettype wire

// [sim/sddma_far_end.sv]
// Purpose: card and memory ends of the data path
// Assumes: sources offer whenever out of reset; sinks stall on request
// Notes:   one numbered stream serves both directions
`default_nettype none
module sddma_far_end (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        stall,
	output logic             src_valid,
	input  wire logic        card_in_ready,
	input  wire logic        mem_in_ready,
	output logic      [15:0] src_data,
	input  wire logic        mem_out_valid,
	input  wire logic [15:0] mem_out_data,
	input  wire logic        card_out_valid,
	input  wire logic [15:0] card_out_data,
	output logic             sink_ready,
	output logic      [15:0] tx_count,
	output logic      [15:0] rx_count,
	output logic      [15:0] seq_err
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        got;
	logic [15:0] word;
	assign src_valid = !sys_rst;
	assign src_data = 16'ha500 + tx_count;
	assign sink_ready = !stall;
	assign got = sink_ready && (mem_out_valid || card_out_valid);
	assign word = mem_out_valid ? mem_out_data : card_out_data;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_count <= 16'h0000;
			rx_count <= 16'h0000;
			seq_err <= 16'h0000;
		end else begin
			if (src_valid && (card_in_ready || mem_in_ready))
				tx_count <= tx_count + 16'h0001;
			if (got)
				rx_count <= rx_count + 16'h0001;
			// words must arrive whole and in order
			if (got && word !== 16'ha500 + rx_count)
				seq_err <= seq_err + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// [sim/sddma_channel_tb.sv]
// Purpose: register and transfer tests of the channel
// Assumes: register strobes one cycle wide, driven 1 ns after the edge
// Notes:   the far end numbers every word it sends
`default_nettype none
module sddma_channel_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, sys_rst, io_wr_en, io_rd_en, io_rvalid, stall;
	logic        card_dma_request, wide_xfer, dma_request_out, src_valid;
	logic        card_in_ready, mem_in_ready, sink_ready;
	logic        mem_out_valid, card_out_valid;
	logic [3:0]  io_addr;
	logic [7:0]  io_wdata, io_rdata;
	logic [15:0] src_data, mem_out_data, card_out_data;
	logic [15:0] tx_count, rx_count, seq_err;
	logic [23:0] addr_phase;
	int          bad_count, n_compared, cyc;
	sddma_channel sddma_channel_i (.clk(clk), .sys_rst(sys_rst),
		.io_addr(io_addr), .io_wr_en(io_wr_en), .io_rd_en(io_rd_en),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
		.card_dma_request(card_dma_request), .wide_xfer(wide_xfer),
		.card_in_valid(src_valid), .card_in_ready(card_in_ready),
		.card_in_data(src_data), .mem_in_valid(src_valid),
		.mem_in_ready(mem_in_ready), .mem_in_data(src_data),
		.mem_out_valid(mem_out_valid), .mem_out_ready(sink_ready),
		.mem_out_data(mem_out_data), .card_out_valid(card_out_valid),
		.card_out_ready(sink_ready), .card_out_data(card_out_data),
		.dma_request_out(dma_request_out), .addr_phase(addr_phase));
	sddma_far_end sddma_far_end_i (.clk(clk), .sys_rst(sys_rst),
		.stall(stall), .src_valid(src_valid), .card_in_ready(card_in_ready),
		.mem_in_ready(mem_in_ready), .src_data(src_data),
		.mem_out_valid(mem_out_valid), .mem_out_data(mem_out_data),
		.card_out_valid(card_out_valid), .card_out_data(card_out_data),
		.sink_ready(sink_ready), .tx_count(tx_count), .rx_count(rx_count),
		.seq_err(seq_err));
	always #5 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
			bad_count++;
		if (got !== exp)
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 io_addr = a;
		io_wdata = d;
		io_wr_en = 1'b1;
		@(posedge clk);
		#1 io_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		#1 io_addr = a;
		io_rd_en = 1'b1;
		@(posedge clk);
		#1 io_rd_en = 1'b0;
		chk({7'h00, io_rvalid, io_rdata}, {8'h01, e});
	endtask
	task automatic run(input logic [7:0] cnt, input logic [7:0] mode);
		wr(4'h4, cnt);
		wr(4'h5, 8'h00);
		wr(4'hb, mode);
	endtask
	task automatic wait_rx(input logic [15:0] n);
		for (int k = 0; k < 300 && rx_count < n; k++) begin
			@(posedge clk);
			#1;
		end
		chk(rx_count, n);
	endtask
	task automatic stop_test;
		$display("compared %0d, mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		{clk, io_wr_en, io_rd_en, io_addr, io_wdata, stall} = '0;
		{card_dma_request, wide_xfer, bad_count, n_compared, cyc} = '0;
		sys_rst = 1'b1;
		repeat (12) @(posedge clk);
		#1 sys_rst = 1'b0;
		rd(4'h4, 8'h00);
		rd(4'h5, 8'h00);
		rd(4'hb, 8'h00);
		rd(4'h8, 8'h00);
		rd(4'hf, 8'h01);
		for (int i = 0; i < 16; i++) begin
			wr(4'hb, {i[3:2], i[0], i[1], i[1:0], 2'b11});
			rd(4'hb, {i[3:2], i[0], i[1], i[1:0], 2'b00});
		end
		card_dma_request = 1'b1;
		repeat (6) @(posedge clk);
		rd(4'h8, 8'hf0);
		card_dma_request = 1'b0;
		repeat (6) @(posedge clk);
		rd(4'h8, 8'h00);
		// block write by software request, sink stalled so the fifo fills
		stall = 1'b1;
		run(8'h10, 8'h84);
		rd(4'h4, 8'h10);
		wr(4'h9, 8'h5a);
		repeat (40) @(posedge clk);
		#1 chk({15'h0000, card_in_ready}, 16'h0000);
		chk({15'h0000, dma_request_out}, 16'h0001);
		chk(rx_count, 16'h0000);
		stall = 1'b0;
		wait_rx(16'h0010);
		rd(4'h4, 8'h00);
		chk({15'h0000, dma_request_out}, 16'h0000);
		rd(4'h8, 8'h0f);
		rd(4'h8, 8'h00);
		wide_xfer = 1'b1;
		run(8'h06, 8'h84);
		wr(4'h9, 8'h00);
		wait_rx(16'h0013);
		repeat (10) @(posedge clk);
		#1 chk(tx_count, 16'h0013);
		wide_xfer = 1'b0;
		// demand read: masked request must be ignored, then served
		run(8'h02, 8'h08);
		card_dma_request = 1'b1;
		repeat (20) @(posedge clk);
		#1 chk(tx_count, 16'h0013);
		chk({15'h0000, dma_request_out}, 16'h0000);
		wr(4'hf, 8'h00);
		wait_rx(16'h0015);
		card_dma_request = 1'b0;
		chk(seq_err, 16'h0000);
		wr(4'h8, 8'hff);
		run(8'h04, 8'h84);
		wr(4'h9, 8'h01);
		repeat (20) @(posedge clk);
		#1 chk(tx_count, 16'h0015);
		chk({15'h0000, dma_request_out}, 16'h0000);
		wr(4'hd, 8'h3c);
		rd(4'h4, 8'h00);
		rd(4'hb, 8'h00);
		rd(4'hf, 8'h01);
		rd(4'h8, 8'h00);
		// page bit 0 must drop out of the 16-bit address phase
		wr(4'h0, 8'h34);
		wr(4'h1, 8'h12);
		wr(4'h2, 8'h57);
		rd(4'h0, 8'h34);
		rd(4'h1, 8'h12);
		rd(4'h2, 8'h57);
		chk(addr_phase[15:0], 16'h1234);
		chk({8'h00, addr_phase[23:16]}, 16'h0057);
		wide_xfer = 1'b1;
		@(posedge clk);
		#1 chk(addr_phase[16:1], 16'h1234);
		chk({8'h00, addr_phase[23:17], addr_phase[0]}, 16'h0056);
		wide_xfer = 1'b0;
		// auto reload while stepping down, then plain runs both ways
		run(8'h03, 8'hb4);
		wr(4'h9, 8'h00);
		wait_rx(16'h0018);
		rd(4'h4, 8'h03);
		rd(4'h0, 8'h34);
		rd(4'h8, 8'h0f);
		run(8'h02, 8'ha4);
		wr(4'h9, 8'h00);
		wait_rx(16'h001a);
		rd(4'h0, 8'h32);
		run(8'h02, 8'h84);
		wr(4'h9, 8'h00);
		wait_rx(16'h001c);
		rd(4'h0, 8'h34);
		chk(seq_err, 16'h0000);
		stop_test();
	end
endmodule
`default_nettype wire
